//--- hw/pdcr_top.sv
// What this block does
// - Output divide ratio is one 9-bit value: bit 8 alone, then low byte.
// - Output divide ratio resets to low byte 0x46, top bit 0.
// - Reference pre-divide bit: 1 divides by four, 0 bypasses; resets 0.
// - Feedback integer is 12 bits: nibble 11:8, then byte 7:0.
// - Feedback integer resets to upper nibble 0x0, low byte 0x31.
// - Numerator is 22 bits over three bytes, top byte holds bits 21:16.
// - Numerator bytes reset to 0x00, 0x01, 0x1f, top first.
// - Denominator is 22 bits laid out like the numerator.
// - Denominator bytes reset to 0x00, 0x02, 0x71, top first.
// - Dither select bits 3:2: 0 weak, 3 off, 1-2 reserved; resets 3.
// - Order select bits 1:0: 0 integer, 3 third order; resets 0.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module pdcr_top #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [pdcr_pkg::OUTDIV_W-1:0] outputDivideRatio,
  output logic referencePredivideSelect,
  output logic [pdcr_pkg::FBINT_W-1:0] feedbackIntegerPart,
  output logic [pdcr_pkg::FRAC_W-1:0] fractionNumerator,
  output logic [pdcr_pkg::FRAC_W-1:0] fractionDenominator,
  output logic [pdcr_pkg::SEL_W-1:0] modulatorDitherSelect,
  output logic [pdcr_pkg::SEL_W-1:0] modulatorOrderSelect,
  output logic fractionActive,
  output logic configFault
);
  import pdcr_pkg::*;

  pdcr_rbus_if rb ();

  pdcr_axil_slave #(
    .ADDR_W(ADDR_W)
  ) uSlave (
    .core_clk(core_clk),
    .rst(rst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rb(rb)
  );

  logic [0:0] outDivHi;
  logic [7:0] outDivLo;
  logic [0:0] refPre;
  logic [3:0] fbIntHi;
  logic [7:0] fbIntLo;
  logic [5:0] numTop;
  logic [7:0] numMid;
  logic [7:0] numBot;
  logic [5:0] denTop;
  logic [7:0] denMid;
  logic [7:0] denBot;
  logic [1:0] ditherSel;
  logic [1:0] orderSel;
  logic [0:0] trimMode;
  logic [FRAC_W-1:0] numLive;
  logic [FRAC_W-1:0] denLive;
  logic [FRAC_W-1:0] numApplied_r;
  logic [FRAC_W-1:0] numApplied_nxt;
  logic [FRAC_W-1:0] numEff;
  logic [OUTDIV_W-1:0] outDivLive;
  logic [BYTE_W-1:0] status;
  logic fracOn;

  // Write strobe per register
  function automatic logic hitW(input logic [IDX_W-1:0] idx);
    hitW = rb.wrEn && (rb.wrIdx == idx);
  endfunction : hitW

  pdcr_field_reg #(
    .WIDTH(1),
    .RESET(RST_OUTDIV_HI)
  ) uOutDivHi (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_OUTDIV_HI)),
    .wrData(rb.wrData[0:0]),
    .q(outDivHi)
  );

  pdcr_field_reg #(
    .WIDTH(8),
    .RESET(RST_OUTDIV_LO)
  ) uOutDivLo (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_OUTDIV_LO)),
    .wrData(rb.wrData),
    .q(outDivLo)
  );

  pdcr_field_reg #(
    .WIDTH(1),
    .RESET(RST_REFPRE)
  ) uRefPre (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_REFPRE)),
    .wrData(rb.wrData[0:0]),
    .q(refPre)
  );

  pdcr_field_reg #(
    .WIDTH(4),
    .RESET(RST_FBINT_HI)
  ) uFbIntHi (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_FBINT_HI)),
    .wrData(rb.wrData[NIB_W-1:0]),
    .q(fbIntHi)
  );

  pdcr_field_reg #(
    .WIDTH(8),
    .RESET(RST_FBINT_LO)
  ) uFbIntLo (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_FBINT_LO)),
    .wrData(rb.wrData),
    .q(fbIntLo)
  );

  pdcr_field_reg #(
    .WIDTH(6),
    .RESET(RST_NUM_TOP)
  ) uNumTop (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_NUM_TOP)),
    .wrData(rb.wrData[TOP6_W-1:0]),
    .q(numTop)
  );

  pdcr_field_reg #(
    .WIDTH(8),
    .RESET(RST_NUM_MID)
  ) uNumMid (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_NUM_MID)),
    .wrData(rb.wrData),
    .q(numMid)
  );

  pdcr_field_reg #(
    .WIDTH(8),
    .RESET(RST_NUM_BOT)
  ) uNumBot (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_NUM_BOT)),
    .wrData(rb.wrData),
    .q(numBot)
  );

  pdcr_field_reg #(
    .WIDTH(6),
    .RESET(RST_DEN_TOP)
  ) uDenTop (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_DEN_TOP)),
    .wrData(rb.wrData[TOP6_W-1:0]),
    .q(denTop)
  );

  pdcr_field_reg #(
    .WIDTH(8),
    .RESET(RST_DEN_MID)
  ) uDenMid (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_DEN_MID)),
    .wrData(rb.wrData),
    .q(denMid)
  );

  pdcr_field_reg #(
    .WIDTH(8),
    .RESET(RST_DEN_BOT)
  ) uDenBot (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_DEN_BOT)),
    .wrData(rb.wrData),
    .q(denBot)
  );

  // Reserved codes are stored as written; status flags them
  pdcr_field_reg #(
    .WIDTH(2),
    .RESET(RST_DITHER)
  ) uDither (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_MODCTL)),
    .wrData(rb.wrData[DITHER_LSB+:SEL_W]),
    .q(ditherSel)
  );

  pdcr_field_reg #(
    .WIDTH(2),
    .RESET(RST_ORDER)
  ) uOrder (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_MODCTL)),
    .wrData(rb.wrData[ORDER_LSB+:SEL_W]),
    .q(orderSel)
  );

  pdcr_field_reg #(
    .WIDTH(1),
    .RESET(RST_TRIM)
  ) uTrim (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(hitW(IDX_TRIMCTL)),
    .wrData(rb.wrData[TRIM_BIT:TRIM_BIT]),
    .q(trimMode)
  );

  assign outDivLive = {outDivHi, outDivLo};
  assign numLive = {numTop, numMid, numBot};
  assign denLive = {denTop, denMid, denBot};
  assign fracOn = (orderSel != ORDER_INTEGER);

  // In trim mode the datapath sees a new numerator only when the bottom
  // byte lands, so a top-first sequence moves the frequency in one step
  always_comb begin
    numApplied_nxt = numApplied_r;
    if (!trimMode[0]) begin
      numApplied_nxt = numLive;
    end else if (hitW(IDX_NUM_BOT)) begin
      numApplied_nxt = {numTop, numMid, rb.wrData};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      numApplied_r <= {RST_NUM_TOP, RST_NUM_MID, RST_NUM_BOT};
    end else begin
      numApplied_r <= numApplied_nxt;
    end
  end

  // Live bytes outside trim mode keep the numerator on the same lag as the rest
  assign numEff = trimMode[0] ? numApplied_r : numLive;

  // Consistency flags; nothing is blocked, software decides
  always_comb begin
    status = '0;
    status[ST_OUTDIV_RSVD] = (outDivLive < OUTDIV_MIN);
    status[ST_DITHER_RSVD] = (ditherSel != DITHER_WEAK) &&
      (ditherSel != DITHER_OFF);
    status[ST_ORDER_RSVD] = (orderSel != ORDER_INTEGER) &&
      (orderSel != ORDER_THIRD);
    status[ST_DEN_ZERO] = (denLive == '0);
    status[ST_NUM_GE_DEN] = fracOn && (numEff >= denLive);
    status[ST_FRAC_ACTIVE] = fracOn;
  end

  // Read mux; reserved bits read as zero
  always_comb begin
    rb.rdData = '0;
    rb.rdHit = 1'b1;
    unique case (rb.rdIdx)
      IDX_OUTDIV_HI: rb.rdData = {7'h00, outDivHi};
      IDX_OUTDIV_LO: rb.rdData = outDivLo;
      IDX_REFPRE: rb.rdData = {7'h00, refPre};
      IDX_FBINT_HI: rb.rdData = {4'h0, fbIntHi};
      IDX_FBINT_LO: rb.rdData = fbIntLo;
      IDX_NUM_TOP: rb.rdData = {2'h0, numTop};
      IDX_NUM_MID: rb.rdData = numMid;
      IDX_NUM_BOT: rb.rdData = numBot;
      IDX_DEN_TOP: rb.rdData = {2'h0, denTop};
      IDX_DEN_MID: rb.rdData = denMid;
      IDX_DEN_BOT: rb.rdData = denBot;
      IDX_MODCTL: rb.rdData = {4'h0, ditherSel, orderSel};
      IDX_TRIMCTL: rb.rdData = {7'h00, trimMode};
      IDX_STATUS: rb.rdData = status;
      default: rb.rdHit = 1'b0;
    endcase
  end

  // Status is read-only; writing it is refused like an unmapped index
  always_comb begin
    unique case (rb.wrIdx)
      IDX_OUTDIV_HI, IDX_OUTDIV_LO, IDX_REFPRE, IDX_FBINT_HI,
      IDX_FBINT_LO, IDX_NUM_TOP, IDX_NUM_MID, IDX_NUM_BOT,
      IDX_DEN_TOP, IDX_DEN_MID, IDX_DEN_BOT, IDX_MODCTL,
      IDX_TRIMCTL: rb.wrHit = 1'b1;
      default: rb.wrHit = 1'b0;
    endcase
  end

  // Datapath outputs, one register stage after the fields
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outputDivideRatio <= {RST_OUTDIV_HI, RST_OUTDIV_LO};
      referencePredivideSelect <= RST_REFPRE[0];
      feedbackIntegerPart <= {RST_FBINT_HI, RST_FBINT_LO};
      fractionNumerator <= '0;
      fractionDenominator <= {RST_DEN_TOP, RST_DEN_MID, RST_DEN_BOT};
      modulatorDitherSelect <= RST_DITHER;
      modulatorOrderSelect <= RST_ORDER;
      fractionActive <= 1'b0;
      configFault <= 1'b0;
    end else begin
      outputDivideRatio <= outDivLive;
      referencePredivideSelect <= refPre[0];
      feedbackIntegerPart <= {fbIntHi, fbIntLo};
      // Integer mode drives a zero numerator to the modulator
      fractionNumerator <= fracOn ? numEff : '0;
      fractionDenominator <= denLive;
      modulatorDitherSelect <= ditherSel;
      modulatorOrderSelect <= orderSel;
      fractionActive <= fracOn;
      configFault <= |status[ST_NUM_GE_DEN:ST_OUTDIV_RSVD];
    end
  end
endmodule : pdcr_top

//--- pkg/pdcr_pkg.sv
package pdcr_pkg;
  localparam int IDX_W = 6;
  localparam int BYTE_W = 8;
  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OUTDIV_HI = 6'h16;
  localparam logic [IDX_W-1:0] IDX_OUTDIV_LO = 6'h17;
  localparam logic [IDX_W-1:0] IDX_REFPRE = 6'h18;
  localparam logic [IDX_W-1:0] IDX_FBINT_HI = 6'h19;
  localparam logic [IDX_W-1:0] IDX_FBINT_LO = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_NUM_TOP = 6'h1b;
  localparam logic [IDX_W-1:0] IDX_NUM_MID = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_NUM_BOT = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_DEN_TOP = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_DEN_MID = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_DEN_BOT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_MODCTL = 6'h21;
  localparam logic [IDX_W-1:0] IDX_TRIMCTL = 6'h30;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h31;
  // Field widths
  localparam int OUTDIV_W = 9;
  localparam int FBINT_W = 12;
  localparam int FRAC_W = 22;
  localparam int TOP6_W = 6;
  localparam int NIB_W = 4;
  localparam int SEL_W = 2;
  // Field positions
  localparam int DITHER_LSB = 2;
  localparam int ORDER_LSB = 0;
  localparam int TRIM_BIT = 0;
  localparam int ST_OUTDIV_RSVD = 0;
  localparam int ST_DITHER_RSVD = 1;
  localparam int ST_ORDER_RSVD = 2;
  localparam int ST_DEN_ZERO = 3;
  localparam int ST_NUM_GE_DEN = 4;
  localparam int ST_FRAC_ACTIVE = 5;
  // Values after reset
  localparam logic [0:0] RST_OUTDIV_HI = 1'h0;
  localparam logic [7:0] RST_OUTDIV_LO = 8'h46;
  localparam logic [0:0] RST_REFPRE = 1'h0;
  localparam logic [3:0] RST_FBINT_HI = 4'h0;
  localparam logic [7:0] RST_FBINT_LO = 8'h31;
  localparam logic [5:0] RST_NUM_TOP = 6'h00;
  localparam logic [7:0] RST_NUM_MID = 8'h01;
  localparam logic [7:0] RST_NUM_BOT = 8'h1f;
  localparam logic [5:0] RST_DEN_TOP = 6'h00;
  localparam logic [7:0] RST_DEN_MID = 8'h02;
  localparam logic [7:0] RST_DEN_BOT = 8'h71;
  localparam logic [1:0] RST_DITHER = 2'h3;
  localparam logic [1:0] RST_ORDER = 2'h0;
  localparam logic [0:0] RST_TRIM = 1'h0;
  // Encodings and limits
  localparam logic [1:0] DITHER_WEAK = 2'h0;
  localparam logic [1:0] DITHER_OFF = 2'h3;
  localparam logic [1:0] ORDER_INTEGER = 2'h0;
  localparam logic [1:0] ORDER_THIRD = 2'h3;
  localparam logic [8:0] OUTDIV_MIN = 9'h005;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pdcr_pkg

//--- pkg/pdcr_rbus_if.sv
`timescale 1ns/1ps
interface pdcr_rbus_if;
  import pdcr_pkg::*;
  logic wrEn;
  logic [IDX_W-1:0] wrIdx;
  logic [BYTE_W-1:0] wrData;
  logic wrHit;
  logic [IDX_W-1:0] rdIdx;
  logic [BYTE_W-1:0] rdData;
  logic rdHit;
  modport slave (output wrEn, wrIdx, wrData, rdIdx,
    input wrHit, rdData, rdHit);
  modport regs (input wrEn, wrIdx, wrData, rdIdx,
    output wrHit, rdData, rdHit);
endinterface : pdcr_rbus_if

//--- hw/pdcr_field_reg.sv
`timescale 1ns/1ps
module pdcr_field_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] q
);
  if (WIDTH < 1 || WIDTH > 8) begin : gBadWidth
    $error("pdcr_field_reg: WIDTH must be 1 to 8");
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= RESET;
    end else if (wrEn) begin
      q <= wrData;
    end
  end
endmodule : pdcr_field_reg

//--- hw/pdcr_axil_slave.sv
`timescale 1ns/1ps
module pdcr_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  pdcr_rbus_if.slave rb
);
  import pdcr_pkg::*;
  if (ADDR_W < IDX_W + 2) begin : gBadAddr
    $error("pdcr_axil_slave: ADDR_W too small for the map");
  end
  logic [IDX_W-1:0] awIdx_r;
  logic [BYTE_W-1:0] wByte_r;
  logic wLane0_r;
  logic [IDX_W-1:0] arIdx_r;
  logic rPend_r;
  logic fire;
  // Address and data are held until both are in, in either order
  assign fire = ~awready & ~wready & ~bvalid;
  // A write without lane 0 is answered but changes nothing
  assign rb.wrEn = fire & wLane0_r;
  assign rb.wrIdx = awIdx_r;
  assign rb.wrData = wByte_r;
  assign rb.rdIdx = arIdx_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      awready <= 1'b1;
      awIdx_r <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awIdx_r <= awaddr[IDX_W+1:2];
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wready <= 1'b1;
      wByte_r <= '0;
      wLane0_r <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wByte_r <= wdata[BYTE_W-1:0];
      wLane0_r <= wstrb[0];
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (fire) begin
      bvalid <= 1'b1;
      bresp <= rb.wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arready <= 1'b1;
      arIdx_r <= '0;
      rPend_r <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      arIdx_r <= araddr[IDX_W+1:2];
      rPend_r <= 1'b1;
    end else if (rPend_r) begin
      rPend_r <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rb.rdData};
      rresp <= rb.rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : pdcr_axil_slave

//--- sim/pdcr_top_asserts.sv
`timescale 1ns/1ps
module pdcr_top_asserts
  import pdcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [OUTDIV_W-1:0] outputDivideRatio,
  input wire logic referencePredivideSelect,
  input wire logic [FBINT_W-1:0] feedbackIntegerPart,
  input wire logic [FRAC_W-1:0] fractionNumerator,
  input wire logic [FRAC_W-1:0] fractionDenominator,
  input wire logic [SEL_W-1:0] modulatorDitherSelect,
  input wire logic [SEL_W-1:0] modulatorOrderSelect,
  input wire logic fractionActive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Reset checks must run while reset is high, so no disable there
  a_reset_outdiv: assert property (disable iff (1'b0) rst |=>
    outputDivideRatio == {RST_OUTDIV_HI, RST_OUTDIV_LO})
    else $error("output divider not at reset value");
  a_reset_fbint: assert property (disable iff (1'b0) rst |=>
    feedbackIntegerPart == {RST_FBINT_HI, RST_FBINT_LO})
    else $error("feedback integer not at reset value");
  a_reset_den: assert property (disable iff (1'b0) rst |=>
    fractionDenominator == {RST_DEN_TOP, RST_DEN_MID, RST_DEN_BOT})
    else $error("denominator not at reset value");
  a_reset_modctl: assert property (disable iff (1'b0) rst |=>
    modulatorOrderSelect == RST_ORDER && !referencePredivideSelect &&
    modulatorDitherSelect == RST_DITHER)
    else $error("control fields not at reset value");
  a_order_active: assert property (fractionActive ==
    (modulatorOrderSelect != ORDER_INTEGER))
    else $error("fraction active does not follow order");
  a_num_gated: assert property (modulatorOrderSelect == ORDER_INTEGER
    |-> fractionNumerator == '0)
    else $error("numerator applied in integer mode");
  a_outdiv_on_write: assert property ($changed(outputDivideRatio)
    |-> $past(s_axi_bvalid))
    else $error("output divider changed without a write");
  a_fbint_on_write: assert property ($changed(feedbackIntegerPart)
    |-> $past(s_axi_bvalid))
    else $error("feedback integer changed without a write");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready
    |=> !s_axi_rvalid ##1 s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer not two cycles after take");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_arvalid && s_axi_arready);
  c_frac: cover property ($rose(fractionActive));
endmodule : pdcr_top_asserts

bind pdcr_top pdcr_top_asserts chk_u (.core_clk(core_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .outputDivideRatio(outputDivideRatio),
  .referencePredivideSelect(referencePredivideSelect),
  .feedbackIntegerPart(feedbackIntegerPart),
  .fractionNumerator(fractionNumerator),
  .fractionDenominator(fractionDenominator),
  .modulatorDitherSelect(modulatorDitherSelect),
  .modulatorOrderSelect(modulatorOrderSelect),
  .fractionActive(fractionActive));

//--- sim/tb_pll_divider_config_regs.sv
`timescale 1ns/1ps
module tb_pll_divider_config_regs;
  import pdcr_pkg::*;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin errCount++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awAddr = 8'h00;
  logic [7:0] arAddr = 8'h00;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'h0;
  logic awReady, wReady, bValid, arReady, rValid, preSel, fracAct, cfgFault;
  logic [1:0] bResp, rResp, dithSel, ordSel;
  logic [31:0] rData;
  logic [OUTDIV_W-1:0] outDiv;
  logic [FBINT_W-1:0] fbInt;
  logic [FRAC_W-1:0] fracNum, fracDen;
  int regs[int];
  int applied, errCount = 0, checks = 0, seed = 32'hcfac;

  always #20 core_clk = ~core_clk;

  pdcr_top dut_u (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .outputDivideRatio(outDiv),
    .referencePredivideSelect(preSel), .feedbackIntegerPart(fbInt),
    .fractionNumerator(fracNum), .fractionDenominator(fracDen),
    .modulatorDitherSelect(dithSel), .modulatorOrderSelect(ordSel),
    .fractionActive(fracAct), .configFault(cfgFault));

  task automatic giveVerdict();
    $display("mismatches %0d comparisons %0d", errCount, checks);
    if (errCount == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : giveVerdict

  function automatic void modelReset();
    regs = '{8'h16: 8'h00, 8'h17: 8'h46, 8'h18: 8'h00, 8'h19: 8'h00,
      8'h1a: 8'h31, 8'h1b: 8'h00, 8'h1c: 8'h01, 8'h1d: 8'h1f, 8'h1e: 8'h00,
      8'h1f: 8'h02, 8'h20: 8'h71, 8'h21: 8'h0c, 8'h30: 8'h00};
    applied = regs[8'h1b] << 16 | regs[8'h1c] << 8 | regs[8'h1d];
  endfunction : modelReset

  // Reserved bits are dropped on write, so the mask is the stored width
  function automatic int maskOf(int i);
    case (i)
      8'h16, 8'h18, 8'h30: return 8'h01;
      8'h19, 8'h21: return 8'h0f;
      8'h1b, 8'h1e: return 8'h3f;
      default: return 8'hff;
    endcase
  endfunction : maskOf

  function automatic logic [5:0] status();
    int od, dt, ord, dn;
    od = regs[8'h16] << 8 | regs[8'h17];
    dt = regs[8'h21] >> 2;
    ord = regs[8'h21] & 8'h03;
    dn = regs[8'h1e] << 16 | regs[8'h1f] << 8 | regs[8'h20];
    return {ord != 0, ord != 0 && applied >= dn, dn == 0,
      ord == 1 || ord == 2, dt == 1 || dt == 2, od < 5};
  endfunction : status

  task automatic portCheck();
    int ord;
    logic [5:0] s;
    ord = regs[8'h21] & 8'h03;
    s = status();
    `CHK(outDiv, 9'(regs[8'h16] << 8 | regs[8'h17]))
    `CHK(preSel, 1'(regs[8'h18]))
    `CHK(fbInt, 12'(regs[8'h19] << 8 | regs[8'h1a]))
    `CHK(fracNum, 22'(ord != 0 ? applied : 0))
    `CHK(fracDen, 22'(regs[8'h1e] << 16 | regs[8'h1f] << 8 | regs[8'h20]))
    `CHK(dithSel, 2'(regs[8'h21] >> 2))
    `CHK(ordSel, 2'(ord))
    `CHK(fracAct, ord != 0)
    `CHK(cfgFault, |s[4:0])
  endtask : portCheck

  task automatic wr(input int i, input int d, input logic [3:0] st = 4'hf);
    logic [1:0] r;
    int n;
    @(posedge core_clk);
    awAddr <= 8'(i * 4);
    awValid <= 1'b1;
    wData <= d;
    wStrb <= st;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) begin
        r = bResp;
        bReady <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      errCount++;
      giveVerdict();
    end
    `CHK(r, regs.exists(i) ? RESP_OKAY : RESP_SLVERR)
    if (regs.exists(i) && st[0]) begin
      regs[i] = d & maskOf(i);
      // In trim mode only the bottom byte moves the applied numerator
      if (regs[8'h30] == 0 || i == 8'h1d)
        applied = regs[8'h1b] << 16 | regs[8'h1c] << 8 | regs[8'h1d];
    end
    @(negedge core_clk);
    portCheck();
  endtask : wr

  task automatic rd(input int i);
    logic [7:0] e;
    int n;
    @(posedge core_clk);
    arAddr <= 8'(i * 4);
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) begin
        rReady <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      errCount++;
      giveVerdict();
    end
    e = i == 8'h31 ? 8'(status()) : regs.exists(i) ? 8'(regs[i]) : 8'h00;
    `CHK(rData, {24'h0, e})
    `CHK(rResp, (regs.exists(i) || i == 8'h31) ? RESP_OKAY : RESP_SLVERR)
  endtask : rd

  initial begin
    int k;
    modelReset();
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    portCheck();
    foreach (regs[j]) rd(j);
    rd(8'h31);
    // Upper data bits are random too, to show they are dropped
    for (k = 0; k < 3; k++) foreach (regs[j]) begin
      wr(j, $random(seed));
      rd(j);
    end
    for (k = 0; k < 16; k++) begin
      wr(8'h21, k);
      rd(8'h31);
    end
    // Divider ratio edges: reserved 4, lowest legal 5, highest 511
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h04);
    rd(8'h31);
    wr(8'h17, 8'h05);
    rd(8'h31);
    wr(8'h16, 8'h01);
    wr(8'h17, 8'hff);
    for (k = 8'h1e; k <= 8'h20; k++) wr(k, 8'h00);
    rd(8'h31);
    wr(8'h17, 8'h99, 4'he);
    rd(8'h17);
    wr(8'h31, 8'h01);
    wr(8'h3f, 8'h01);
    rd(8'h3f);
    rd(8'h00);
    wr(8'h20, 8'h71);
    wr(8'h21, 8'h03);
    wr(8'h30, 8'h01);
    wr(8'h1b, 8'h3f);
    wr(8'h1c, 8'h22);
    wr(8'h1d, 8'h10);
    wr(8'h30, 8'h00);
    // Second reset in mid-run must restore every field
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    modelReset();
    @(negedge core_clk);
    portCheck();
    rd(8'h21);
    giveVerdict();
  end
endmodule : tb_pll_divider_config_regs
